// ---- design/msd_params.svh ----
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH
`define MSD_OFS_CONTROL      4'h0
`define MSD_OFS_KEY          4'h4
`define MSD_OFS_STATUS       4'h8
`define MSD_OFS_SEGMENTS     4'hC
`define MSD_BIT_DATA_WIDE    0
`define MSD_BIT_PROG_WIDE    1
`define MSD_CTRL_UNUSED_ONES 8'hFC
`define MSD_KEY_FIRST        4'h5
`define MSD_KEY_SECOND       4'hA
`define MSD_INT_CYCLES_NARROW 5'h0E
`define MSD_INT_CYCLES_WIDE   5'h11
`define MSD_IRQ_CLEAR_CYCLE   5'h03
`define MSD_INT_ROM_TOP       20'h1FFFF
`define MSD_VEC_PIN          16'h0000
`define MSD_VEC_BREAK        16'h0002
`define MSD_VEC_WATCHDOG     16'h0004
`define MSD_VEC_TRAP         16'h0006
`endif

// ---- design/msd_pkg.sv ----
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_RST_PIN,
    MSD_RST_BREAK,
    MSD_RST_WATCHDOG,
    MSD_RST_TRAP
  } msd_reset_src_t;

  typedef enum logic [1:0] {
    MSD_KEY_IDLE,
    MSD_KEY_HALF,
    MSD_KEY_OPEN
  } msd_key_state_t;

  typedef struct packed {
    logic        active;
    logic        is_internal;
    logic        bus_separate;
    logic        latch_strobe;
    logic        read_strobe;
    logic [7:0]  port0_addr;
    logic        port0_oe_n;
    logic [7:0]  port4_addr;
    logic [7:0]  port1_addr;
    logic [3:0]  port2_addr;
  } msd_fetch_bus_t;

  typedef struct packed {
    logic        busy;
    logic        irq_clear;
    logic        push_segment;
    logic [15:0] pc;
    logic [3:0]  segment;
  } msd_int_entry_t;
endpackage

// ---- design/msd_decode.sv ----
`include "msd_params.svh"
// Function
// - Interrupt transfer lasts 14 cycles, 17 wide
// - Clear pending request in third transfer cycle
// - Both spaces limited to 64KB after reset
// - Bit1 widens program, bit0 widens data
// - Unimplemented control bits read as one
// - Far ops while narrow raise opcode trap
// - Widening takes effect after the next two instructions
// - Control register writable once per reset
// - Sixteen segments; table reads use table segment
// - Fetch high: below 20000H internal, above external
// - Fetch low: everything goes external
// - Separate bus: port0 data, ports 4,1,2 address
// - Multiplexed bus: port0 address/data, latch strobe
// - Vector table holds 29 branch vectors
// - Vector low byte even, clears code segment
// - Wide program pushes and restores code segment
// - Segments 0-1 internal while fetch high, 2-15 external
// - Reset vectors at 0,2,4,6 by source
// - Bus select high separate, low multiplexed
module msd_decode #(
  parameter int SEG_BITS = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire msd_pkg::msd_reset_src_t reset_source,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  external_fetch_select,
  input  wire logic                  bus_type_select,
  input  wire logic                  fetch_req,
  input  wire logic                  fetch_is_table,
  input  wire logic [15:0]           fetch_offset,
  input  wire logic                  cs_load,
  input  wire logic [3:0]            cs_value,
  input  wire logic                  ts_load,
  input  wire logic [3:0]            ts_value,
  input  wire logic                  instr_done,
  input  wire logic                  far_op,
  input  wire logic                  int_req,
  input  wire logic [15:0]           int_vector_addr,
  input  wire logic [15:0]           vector_data,
  input  wire logic                  int_return,
  input  wire logic [3:0]            stacked_segment,
  output msd_pkg::msd_fetch_bus_t    fetch_bus,
  output msd_pkg::msd_int_entry_t    int_entry,
  output logic [15:0]                vector_fetch_addr,
  output logic [3:0]                 code_segment,
  output logic                       program_space_wide,
  output logic                       data_space_wide,
  output logic                       opcode_trap
);
  initial begin
    if (SEG_BITS != 4) $error("SEG_BITS must be 4");
    if (`MSD_KEY_FIRST == `MSD_KEY_SECOND) $error("key steps must differ");
    if (`MSD_INT_CYCLES_NARROW <= `MSD_IRQ_CLEAR_CYCLE) $error("transfer too short");
  end

  // Pin inputs cross domains: three stages, act when last two agree
  logic [2:0] ef_sync_reg;
  logic [2:0] bt_sync_reg;
  logic       ef_reg;
  logic       bt_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ef_sync_reg <= 3'h7;
      bt_sync_reg <= 3'h7;
      ef_reg      <= 1'b1;
      bt_reg      <= 1'b1;
    end else if (clk_en) begin
      ef_sync_reg <= {ef_sync_reg[1:0], external_fetch_select};
      bt_sync_reg <= {bt_sync_reg[1:0], bus_type_select};
      if (ef_sync_reg[1] == ef_sync_reg[2]) ef_reg <= ef_sync_reg[2];
      if (bt_sync_reg[1] == bt_sync_reg[2]) bt_reg <= bt_sync_reg[2];
    end
  end

  // Avalon slave: one wait state; a write lands only where waitrequest is low
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic        acc_now;
  logic        wr_now;
  logic        ack_now;

  assign ack_now = !wait_reg;
  assign acc_now = (avs_read || avs_write) && wait_reg;
  assign wr_now  = avs_write && ack_now;

  // Waitrequest idles high so a new request always sees one wait state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_reg <= 1'b1;
    end else if (clk_en) begin
      wait_reg <= !acc_now;
    end
  end
  assign avs_waitrequest = wait_reg;

  // Key sequencer, one per nibble
  msd_pkg::msd_key_state_t key_hi_reg;
  msd_pkg::msd_key_state_t key_lo_reg;

  function automatic msd_pkg::msd_key_state_t key_step(
    input msd_pkg::msd_key_state_t cur,
    input logic [3:0]              nib
  );
    msd_pkg::msd_key_state_t nxt;
    nxt = msd_pkg::MSD_KEY_IDLE;
    if (nib == `MSD_KEY_FIRST) nxt = msd_pkg::MSD_KEY_HALF;
    else if (nib == `MSD_KEY_SECOND && cur == msd_pkg::MSD_KEY_HALF)
      nxt = msd_pkg::MSD_KEY_OPEN;
    return nxt;
  endfunction

  logic key_wr;
  logic ctrl_wr;
  assign key_wr  = wr_now && avs_address == `MSD_OFS_KEY;
  assign ctrl_wr = wr_now && avs_address == `MSD_OFS_CONTROL;

  logic ctrl_used_reg;

  // Program key, upper nibble
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      key_hi_reg <= msd_pkg::MSD_KEY_IDLE;
    end else if (clk_en) begin
      if (key_wr) begin
        key_hi_reg <= key_step(key_hi_reg, avs_writedata[7:4]);
      end else if (ctrl_wr) begin
        key_hi_reg <= msd_pkg::MSD_KEY_IDLE;
      end
    end
  end

  // Data key, lower nibble
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      key_lo_reg <= msd_pkg::MSD_KEY_IDLE;
    end else if (clk_en) begin
      if (key_wr) begin
        key_lo_reg <= key_step(key_lo_reg, avs_writedata[3:0]);
      end else if (ctrl_wr) begin
        key_lo_reg <= msd_pkg::MSD_KEY_IDLE;
      end
    end
  end

  // Control register; each reset source clears it equally
  logic prog_wide_reg;
  logic data_wide_reg;
  logic prog_pend_reg;
  logic data_pend_reg;
  logic eff_prog_reg;
  logic eff_data_reg;
  logic [1:0] instr_cnt_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prog_wide_reg <= 1'b0;
      data_wide_reg <= 1'b0;
      ctrl_used_reg <= 1'b0;
    end else if (clk_en && ctrl_wr && !ctrl_used_reg) begin
      ctrl_used_reg <= 1'b1;
      if (key_hi_reg == msd_pkg::MSD_KEY_OPEN)
        prog_wide_reg <= avs_writedata[`MSD_BIT_PROG_WIDE];
      if (key_lo_reg == msd_pkg::MSD_KEY_OPEN)
        data_wide_reg <= avs_writedata[`MSD_BIT_DATA_WIDE];
    end
  end

  // Widening becomes visible after the second following instruction completes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      eff_prog_reg  <= 1'b0;
      eff_data_reg  <= 1'b0;
      instr_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      if (ctrl_wr && !ctrl_used_reg) begin
        instr_cnt_reg <= 2'h2;
      end else if (instr_cnt_reg != 2'h0 && instr_done) begin
        instr_cnt_reg <= instr_cnt_reg - 2'h1;
        if (instr_cnt_reg == 2'h1) begin
          eff_prog_reg <= prog_wide_reg;
          eff_data_reg <= data_wide_reg;
        end
      end
    end
  end
  assign program_space_wide = eff_prog_reg;
  assign data_space_wide    = eff_data_reg;

  // Opcode trap; the reset controller turns it into a system reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) opcode_trap <= 1'b0;
    else if (clk_en) opcode_trap <= far_op && !eff_prog_reg;
  end

  // Segment registers
  logic [3:0] cs_reg;
  logic [3:0] ts_reg;
  logic       ent_load;

  // Code segment: vector entry wins over a return or a load
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cs_reg <= 4'h0;
    end else if (clk_en) begin
      if (ent_load) cs_reg <= 4'h0;
      else if (int_return && eff_prog_reg) cs_reg <= stacked_segment;
      else if (cs_load && eff_prog_reg) cs_reg <= cs_value;
    end
  end

  // Table segment; only meaningful once program space is wide
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ts_reg <= 4'h0;
    end else if (clk_en) begin
      if (ts_load && eff_prog_reg) ts_reg <= ts_value;
    end
  end
  assign code_segment = cs_reg;

  // Program fetch routing
  function automatic logic is_internal(input logic [19:0] a, input logic ef);
    return ef && (a <= `MSD_INT_ROM_TOP);
  endfunction

  logic [19:0] fa;
  logic        fetch_ext;
  logic        fb_act_reg;
  logic        fb_int_reg;
  logic        fb_sep_reg;
  logic        fb_ale_reg;
  logic        fb_rd_reg;
  logic        fb_p0_oe_n_reg;
  logic [7:0]  fb_p0_reg;
  logic [7:0]  fb_p4_reg;
  logic [7:0]  fb_p1_reg;
  logic [3:0]  fb_p2_reg;

  assign fa        = {fetch_is_table ? ts_reg : cs_reg, fetch_offset};
  assign fetch_ext = fetch_req && !is_internal(fa, ef_reg);

  // Fetch status
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fb_act_reg <= 1'b0;
      fb_int_reg <= 1'b0;
      fb_sep_reg <= 1'b0;
    end else if (clk_en) begin
      fb_act_reg <= fetch_req;
      fb_int_reg <= fetch_req && is_internal(fa, ef_reg);
      fb_sep_reg <= bt_reg;
    end
  end

  // Strobes; port 0 drives only for a multiplexed address phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fb_rd_reg      <= 1'b0;
      fb_ale_reg     <= 1'b0;
      fb_p0_oe_n_reg <= 1'b1;
    end else if (clk_en) begin
      fb_rd_reg      <= fetch_ext;
      fb_ale_reg     <= fetch_ext && !bt_reg;
      fb_p0_oe_n_reg <= !(fetch_ext && !bt_reg);
    end
  end

  // Address ports keep their last value between external fetches
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fb_p0_reg <= 8'h00;
      fb_p4_reg <= 8'h00;
      fb_p1_reg <= 8'h00;
      fb_p2_reg <= 4'h0;
    end else if (clk_en && fetch_ext) begin
      fb_p0_reg <= bt_reg ? 8'h00 : fa[7:0];
      fb_p4_reg <= bt_reg ? fa[7:0] : 8'h00;
      fb_p1_reg <= fa[15:8];
      fb_p2_reg <= fa[19:16];
    end
  end

  assign fetch_bus = '{
    active:       fb_act_reg,
    is_internal:  fb_int_reg,
    bus_separate: fb_sep_reg,
    latch_strobe: fb_ale_reg,
    read_strobe:  fb_rd_reg,
    port0_addr:   fb_p0_reg,
    port0_oe_n:   fb_p0_oe_n_reg,
    port4_addr:   fb_p4_reg,
    port1_addr:   fb_p1_reg,
    port2_addr:   fb_p2_reg
  };

  // Reset vector selection by source
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) vector_fetch_addr <= `MSD_VEC_PIN;
    else if (clk_en && int_req && !int_entry.busy) vector_fetch_addr <= int_vector_addr;
    else if (clk_en && !int_entry.busy) begin
      unique case (reset_source)
        msd_pkg::MSD_RST_PIN:      vector_fetch_addr <= `MSD_VEC_PIN;
        msd_pkg::MSD_RST_BREAK:    vector_fetch_addr <= `MSD_VEC_BREAK;
        msd_pkg::MSD_RST_WATCHDOG: vector_fetch_addr <= `MSD_VEC_WATCHDOG;
        msd_pkg::MSD_RST_TRAP:     vector_fetch_addr <= `MSD_VEC_TRAP;
      endcase
    end
  end

  // Interrupt transfer sequence
  logic [4:0] int_cnt_reg;
  logic [4:0] int_len_reg;
  assign ent_load = int_entry.busy && int_cnt_reg == int_len_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      int_entry   <= '0;
      int_cnt_reg <= 5'h00;
      int_len_reg <= `MSD_INT_CYCLES_NARROW;
    end else if (clk_en) begin
      int_entry.irq_clear <= 1'b0;
      if (!int_entry.busy) begin
        if (int_req) begin
          int_entry.busy         <= 1'b1;
          int_cnt_reg            <= 5'h01;
          int_entry.push_segment <= eff_prog_reg;
          int_len_reg <= eff_prog_reg ? `MSD_INT_CYCLES_WIDE
                                      : `MSD_INT_CYCLES_NARROW;
        end
      end else begin
        int_cnt_reg <= int_cnt_reg + 5'h01;
        if (int_cnt_reg + 5'h01 == `MSD_IRQ_CLEAR_CYCLE)
          int_entry.irq_clear <= 1'b1;
        if (ent_load) begin
          int_entry.busy    <= 1'b0;
          int_entry.pc      <= vector_data;
          int_entry.segment <= 4'h0;
          int_entry.push_segment <= 1'b0;
        end
      end
    end
  end

  // Read data: unused control bits read one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) rdata_reg <= 32'h0;
    else if (clk_en && acc_now) begin
      unique case (avs_address)
        `MSD_OFS_CONTROL: rdata_reg <= {24'h0, `MSD_CTRL_UNUSED_ONES
                                       | {6'h0, prog_wide_reg, data_wide_reg}};
        `MSD_OFS_STATUS:  rdata_reg <= {24'h0, 3'h0, ctrl_used_reg, eff_prog_reg,
                                       eff_data_reg, bt_reg, ef_reg};
        `MSD_OFS_SEGMENTS: rdata_reg <= {24'h0, ts_reg, cs_reg};
        default:          rdata_reg <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = rdata_reg;
endmodule

// ---- verification/msd_decode_sva.sv ----
module msd_decode_sva (
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire logic                    external_fetch_select,
  input wire logic                    far_op,
  input wire msd_pkg::msd_fetch_bus_t fetch_bus,
  input wire msd_pkg::msd_int_entry_t int_entry,
  input wire logic [3:0]              code_segment,
  input wire logic                    program_space_wide,
  input wire logic                    data_space_wide,
  input wire logic                    opcode_trap
);
  logic [5:0] busy_cnt;
  wire        ext = fetch_bus.active && !fetch_bus.is_internal;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_cnt <= 6'h00;
    end else begin
      busy_cnt <= int_entry.busy ? busy_cnt + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Pin goes through a synchroniser, so it must sit still first
  sequence s_ea_low;
    !external_fetch_select [*8];
  endsequence
  chk_trap_narrow: assert property (far_op && !program_space_wide |=> opcode_trap)
    else $error("no trap after far op");
  chk_trap_cause: assert property (opcode_trap |-> $past(far_op) && !$past(program_space_wide))
    else $error("trap without cause");
  chk_reset_narrow: assert property ($fell(reset) |-> !program_space_wide && !data_space_wide)
    else $error("wide after reset");
  chk_xfer_len: assert property ($fell(int_entry.busy) |-> busy_cnt == (program_space_wide ? 6'h11 : 6'h0E))
    else $error("transfer length wrong");
  chk_clear_third: assert property (int_entry.irq_clear |-> int_entry.busy && busy_cnt == 6'h02)
    else $error("request cleared off the third cycle");
  chk_seg_cleared: assert property ($fell(int_entry.busy) |-> ##[0:1] code_segment == 4'h0)
    else $error("segment not cleared");
  chk_push_wide: assert property (int_entry.push_segment |-> program_space_wide && int_entry.busy)
    else $error("segment pushed while narrow");
  chk_ext_low: assert property (s_ea_low ##0 fetch_bus.active |-> !fetch_bus.is_internal)
    else $error("internal fetch with pin low");
  chk_mux_strobes: assert property (ext && !fetch_bus.bus_separate |-> fetch_bus.latch_strobe && fetch_bus.read_strobe && !fetch_bus.port0_oe_n)
    else $error("multiplexed strobes wrong");
  chk_sep_strobes: assert property (ext && fetch_bus.bus_separate |-> fetch_bus.read_strobe && !fetch_bus.latch_strobe && fetch_bus.port0_oe_n)
    else $error("separate bus strobes wrong");
endmodule

// ---- verification/msd_ext_mem.sv ----
module msd_ext_mem (
  input wire logic [15:0] vector_fetch_addr,
  output logic     [15:0] vector_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each byte holds its own low address byte plus 10H
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    return a[7:0] + 8'h10;
  endfunction
  always_comb begin
    vector_data = {rom_byte({vector_fetch_addr[15:1], 1'b1}), rom_byte({vector_fetch_addr[15:1], 1'b0})};
  end
endmodule

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic                    external_fetch_select, bus_type_select, fetch_req, fetch_is_table;
  logic                    cs_load, ts_load, instr_done, far_op, int_req, int_return;
  logic                    program_space_wide, data_space_wide, opcode_trap;
  logic [3:0]              avs_address, cs_value, ts_value, stacked_segment, code_segment;
  logic [15:0]             fetch_offset, int_vector_addr, vector_data, vector_fetch_addr;
  logic [31:0]             avs_writedata, avs_readdata, rd;
  msd_pkg::msd_reset_src_t reset_source;
  msd_pkg::msd_fetch_bus_t fetch_bus;
  msd_pkg::msd_int_entry_t int_entry;
  int                      bad_count, cmp_count, n;
  logic [3:0]              seg_tab [4] = '{4'h1, 4'h2, 4'h0, 4'h3};
  msd_decode uut (.clk_sys, .reset, .clk_en(1'b1), .reset_source, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .external_fetch_select,
    .bus_type_select, .fetch_req, .fetch_is_table, .fetch_offset, .cs_load, .cs_value,
    .ts_load, .ts_value, .instr_done, .far_op, .int_req, .int_vector_addr, .vector_data,
    .int_return, .stacked_segment, .fetch_bus, .int_entry, .vector_fetch_addr, .code_segment,
    .program_space_wide, .data_space_wide, .opcode_trap);
  msd_ext_mem ext_mem (.vector_fetch_addr, .vector_data);
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that runs out is a mismatch and ends the run
  task automatic give_up();
    check(32'h0, 32'h1);
    finish_test();
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) give_up();
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic step(input logic d, input logic f, input logic r, input logic c);
    @(posedge clk_sys);
    instr_done <= d;
    far_op     <= f;
    int_return <= r;
    cs_load    <= c;
    ts_load    <= c;
    @(posedge clk_sys);
    instr_done <= 1'b0;
    far_op     <= 1'b0;
    int_return <= 1'b0;
    cs_load    <= 1'b0;
    ts_load    <= 1'b0;
  endtask
  task automatic wait_busy(input logic lvl);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (int_entry.busy !== lvl && n < 40);
    if (int_entry.busy !== lvl) give_up();
  endtask
  task automatic do_reset(input msd_pkg::msd_reset_src_t src, input int k);
    @(posedge clk_sys);
    reset_source <= src;
    reset        <= 1'b1;
    repeat (k) @(posedge clk_sys);
    reset <= 1'b0;
    tick(6);
    check(32'(vector_fetch_addr), {29'h0, src, 1'b0});
  endtask
  // Vector 001AH holds bytes 2AH, 2BH, so entry lands at 2B2AH
  task automatic int_go();
    @(posedge clk_sys);
    int_req         <= 1'b1;
    int_vector_addr <= 16'h001A;
    wait_busy(1'b1);
    int_req <= 1'b0;
    wait_busy(1'b0);
    tick(2);
    check(32'(int_entry.pc), 32'h2B2A);
    check(32'(code_segment), 32'h0);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {avs_read, avs_write, fetch_req, fetch_is_table, cs_load, ts_load} = '0;
    {instr_done, far_op, int_req, int_return, bad_count, cmp_count} = '0;
    {avs_address, cs_value, ts_value, stacked_segment, fetch_offset, int_vector_addr} = '0;
    avs_writedata = '0;
    reset = 1'b1;
    external_fetch_select = 1'b1;
    bus_type_select = 1'b1;
    reset_source = msd_pkg::MSD_RST_PIN;
    do_reset(msd_pkg::MSD_RST_PIN, 19);
    rdchk(4'h0, 32'h000000FC);
    rdchk(4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h03);
    rdchk(4'h0, 32'h000000FC);
    bus(1'b1, 4'h4, 32'h55);
    bus(1'b1, 4'h4, 32'hAA);
    bus(1'b1, 4'h0, 32'h03);
    rdchk(4'h0, 32'h000000FC);
    int_go();
    step(1'b0, 1'b1, 1'b0, 1'b0);
    tick(1);
    check(32'(opcode_trap), 32'h1);
    $display("test 1 done");
    do_reset(msd_pkg::MSD_RST_TRAP, 3);
    bus(1'b1, 4'h4, 32'h55);
    bus(1'b1, 4'h4, 32'h35);
    bus(1'b1, 4'h4, 32'hAA);
    bus(1'b1, 4'h0, 32'h03);
    rdchk(4'h0, 32'h000000FD);
    check(32'(data_space_wide), 32'h0);
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0, 1'b0);
    tick(2);
    check(32'({program_space_wide, data_space_wide}), 32'h1);
    $display("test 2 done");
    do_reset(msd_pkg::MSD_RST_BREAK, 3);
    bus(1'b1, 4'h4, 32'h50);
    bus(1'b1, 4'h4, 32'hA0);
    bus(1'b1, 4'h0, 32'h02);
    rdchk(4'h0, 32'h000000FE);
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0, 1'b0);
    tick(2);
    check(32'(program_space_wide), 32'h1);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    tick(1);
    check(32'(opcode_trap), 32'h0);
    // Table read uses segment 3 while the code segment is 0; only the segment 1 fetch is internal
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      external_fetch_select <= (i != 2);
      bus_type_select       <= (i != 2);
      cs_value              <= (i == 3) ? 4'h0 : seg_tab[i];
      ts_value              <= 4'h3;
      fetch_is_table        <= (i == 3);
      fetch_offset          <= 16'h1234;
      step(1'b0, 1'b0, 1'b0, 1'b1);
      fetch_req <= 1'b1;
      tick(10);
      if (i == 0) check(32'(fetch_bus.is_internal), 32'h1);
      else check(32'({fetch_bus.is_internal, fetch_bus.bus_separate, fetch_bus.port2_addr,
        fetch_bus.port1_addr, (i == 2) ? fetch_bus.port0_addr : fetch_bus.port4_addr}),
        32'({1'b0, i != 2, seg_tab[i], 16'h1234}));
      fetch_req <= 1'b0;
    end
    cs_value <= 4'h2;
    step(1'b0, 1'b0, 1'b0, 1'b1);
    int_go();
    stacked_segment <= 4'h2;
    step(1'b0, 1'b0, 1'b1, 1'b0);
    tick(2);
    check(32'(code_segment), 32'h2);
    $display("test 3 done");
    do_reset(msd_pkg::MSD_RST_WATCHDOG, 3);
    $display("test 4 done");
    finish_test();
  end
endmodule
bind msd_decode msd_decode_sva chk (.clk_sys, .reset, .external_fetch_select, .far_op,
  .fetch_bus, .int_entry, .code_segment, .program_space_wide, .data_space_wide, .opcode_trap);
